// ==== hw/adcc_prescaler.sv ====
// Purpose: Converter clock prescaler, one tick per DIV clocks
// Assumes: i_run low holds it in reset
// Notes: i_restart zeroes the phase
`timescale 1ns/10ps
`default_nettype none
module adcc_prescaler #(
  parameter int DIV = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Control
  input wire logic i_run,
  input wire logic i_restart,
  // Tick
  output logic o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (!i_run || i_restart) begin
        cnt <= '0;
        o_tick <= 1'b0;
      end else if (cnt == LAST) begin
        cnt <= '0;
        o_tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        o_tick <= 1'b0;
      end
    end
  end
endmodule : adcc_prescaler
`default_nettype wire

// ==== hw/adcc_top.sv ====
// Purpose: Control of a 10-bit successive-approximation converter behind APB
// Assumes: Core result is valid at completion; trigger inputs are synchronous levels
// Notes: One APB wait state; start bit reads as busy
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defs.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int PRESC_DIV = `ADCC_PRESC_DIV,
  parameter int NSRC = 8
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Trigger sources, bit 0 unused
  input wire logic [NSRC-1:0] i_trig_src,
  // Analog core
  input wire logic [9:0] i_core_result,
  output logic o_core_enable,
  output logic o_core_start,
  output logic [4:0] o_core_channel,
  output logic [1:0] o_core_ref,
  // Status
  output logic o_conv_done
);
  adcc_state_t state;
  adcc_state_t next_state;
  logic auto_en;
  logic done_flag;
  logic [2:0] tss;
  logic [1:0] sh_ref;
  logic [4:0] sh_ch;
  logic ladj;
  logic [9:0] result;
  logic lock;
  logic first_pend;
  logic [4:0] cyc_cnt;
  logic done_q;
  logic tick;
  logic trig_edge;
  logic fire;
  logic sw_start;
  logic conv_end;
  logic [4:0] limit;
  logic acc;
  logic wr;
  logic rd;
  logic hit;
  logic [7:0] rdmux;
  logic [7:0] rlo;
  logic [7:0] rhi;
  logic en_wr;

  // APB access strobes
  assign acc = i_psel & i_penable & o_pready & i_ce;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign en_wr = wr && (i_paddr == `ADCC_OFF_CSA);

  // Result presentation
  always_comb begin
    if (ladj) begin
      rhi = result[9:2];
      rlo = {result[1:0], 6'h00};
    end else begin
      rhi = {6'h00, result[9:8]};
      rlo = result[7:0];
    end
  end

  // Read decode
  always_comb begin
    hit = 1'b1;
    rdmux = 8'h00;
    case (i_paddr)
      `ADCC_OFF_CSA: rdmux = {o_core_enable, state != st_idle, auto_en, done_flag, 4'h0};
      `ADCC_OFF_ISR: rdmux = {sh_ref, ladj, sh_ch};
      `ADCC_OFF_RLO: rdmux = rlo;
      `ADCC_OFF_RHI: rdmux = rhi;
      `ADCC_OFF_SFIO: rdmux = {tss, 5'h00};
      default: hit = 1'b0;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_ce) begin
      if (i_psel && i_penable && !o_pready) begin
        o_pready <= 1'b1;
        o_pslverr <= ~hit;
        o_prdata <= {24'h00_0000, rdmux};
      end else begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
      end
    end
  end

  // Control and selection registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_enable <= 1'b0;
      auto_en <= 1'b0;
      tss <= `ADCC_RST_TSS;
      sh_ref <= `ADCC_RST_REF;
      sh_ch <= `ADCC_RST_CH;
      ladj <= 1'b0;
    end else if (wr) begin
      case (i_paddr)
        `ADCC_OFF_CSA: begin
          o_core_enable <= i_pwdata[`ADCC_CSA_EN];
          auto_en <= i_pwdata[`ADCC_CSA_AUTO];
        end
        `ADCC_OFF_ISR: begin
          sh_ref <= i_pwdata[`ADCC_ISR_REF_HI:`ADCC_ISR_REF_LO];
          ladj <= i_pwdata[`ADCC_ISR_LADJ];
          sh_ch <= i_pwdata[`ADCC_ISR_CH_HI:0];
        end
        `ADCC_OFF_SFIO: tss <= i_pwdata[`ADCC_SFIO_TSS_HI:`ADCC_SFIO_TSS_LO];
        default: ;
      endcase
    end
  end

  // Active selection follows shadow only while enabled and not converting
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_channel <= `ADCC_RST_CH;
      o_core_ref <= `ADCC_RST_REF;
    end else if (i_ce && o_core_enable && next_state != st_conv && state != st_conv) begin
      o_core_channel <= sh_ch;
      o_core_ref <= sh_ref;
    end
  end

  adcc_prescaler #(
    .DIV(PRESC_DIV)
  ) u_presc (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_run(o_core_enable),
    .i_restart(fire),
    .o_tick(tick)
  );

  adcc_trig_edge #(
    .NSRC(NSRC)
  ) u_trig (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_sel(tss),
    .i_src(i_trig_src),
    .i_done_pulse(done_q),
    .o_edge(trig_edge)
  );

  // Start conditions
  assign fire = i_ce & o_core_enable & auto_en & trig_edge & (state == st_idle);
  assign sw_start = en_wr & i_pwdata[`ADCC_CSA_START] & i_pwdata[`ADCC_CSA_EN];
  assign limit = first_pend ? `ADCC_FIRST_CYC : `ADCC_CONV_CYC;
  assign conv_end = i_ce & (state == st_conv) & tick & (cyc_cnt == limit - 5'd1);

  // Conversion sequencing
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (fire) begin
          next_state = st_conv;
        end else if (sw_start) begin
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (tick) begin
          next_state = st_conv;
        end
      end
      st_conv: begin
        if (conv_end) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
    if (!o_core_enable) begin
      next_state = st_idle;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= st_idle;
      o_core_start <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      o_core_start <= (next_state == st_conv) && (state != st_conv);
    end
  end

  // Converter clock cycle count
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_cnt <= 5'd0;
    end else if (i_ce) begin
      if (state != st_conv) begin
        cyc_cnt <= 5'd0;
      end else if (tick) begin
        cyc_cnt <= cyc_cnt + 5'd1;
      end
    end
  end

  // First conversion after enabling is the long one
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_pend <= 1'b0;
    end else if (en_wr && i_pwdata[`ADCC_CSA_EN] && !o_core_enable) begin
      first_pend <= 1'b1;
    end else if (conv_end) begin
      first_pend <= 1'b0;
    end
  end

  // Completion event fed back as a trigger source
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_q <= 1'b0;
    end else if (i_ce) begin
      done_q <= conv_end;
    end
  end

  // Done flag, set wins over clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_flag <= 1'b0;
    end else if (conv_end) begin
      done_flag <= 1'b1;
    end else if (en_wr && i_pwdata[`ADCC_CSA_DONE]) begin
      done_flag <= 1'b0;
    end
  end
  assign o_conv_done = done_flag;

  // Result and read-order block
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result <= 10'h000;
    end else if (conv_end && !lock) begin
      result <= i_core_result;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock <= 1'b0;
    end else if (rd && i_paddr == `ADCC_OFF_RLO) begin
      lock <= 1'b1;
    end else if (rd && i_paddr == `ADCC_OFF_RHI) begin
      lock <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_edge_idle;
    (state == st_idle) && fire;
  endsequence
  sequence s_conv_started;
    (state == st_conv) && o_core_start;
  endsequence

  property p_end_clears_start;
    conv_end |=> (state == st_idle);
  endproperty
  a_end_clears_start: assert property (p_end_clears_start) else $error("start bit not cleared at end");

  property p_result_with_flag;
    conv_end && !lock |=> done_flag && (result == $past(i_core_result));
  endproperty
  a_result_with_flag: assert property (p_result_with_flag) else $error("result and flag not together");

  property p_blocked_keeps;
    conv_end && lock |=> (result == $past(result)) && done_flag;
  endproperty
  a_blocked_keeps: assert property (p_blocked_keeps) else $error("blocked result changed");

  property p_flag_every_end;
    conv_end |=> done_flag;
  endproperty
  a_flag_every_end: assert property (p_flag_every_end) else $error("done flag missed");

  property p_edge_ignored;
    (state == st_conv) && trig_edge && i_ce |=> !o_core_start;
  endproperty
  a_edge_ignored: assert property (p_edge_ignored) else $error("edge restarted busy converter");

  property p_trig_starts;
    s_edge_idle |=> s_conv_started;
  endproperty
  a_trig_starts: assert property (p_trig_starts) else $error("trigger edge did not start");

  property p_channel_locked;
    (state == st_conv) && i_ce && !conv_end && o_core_enable |=> $stable(o_core_channel);
  endproperty
  a_channel_locked: assert property (p_channel_locked) else $error("channel changed mid conversion");

  property p_disabled_hold;
    !o_core_enable |=> $stable(o_core_channel) && $stable(o_core_ref);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold) else $error("selection applied while disabled");

  property p_lock_order;
    rd && (i_paddr == `ADCC_OFF_RLO) |=> lock ##0 (!lock || !(rd && i_paddr == `ADCC_OFF_RHI)) [*1] ##1 1'b1;
  endproperty
  a_lock_order: assert property (p_lock_order) else $error("low read did not block");

  property p_unlock;
    rd && (i_paddr == `ADCC_OFF_RHI) |=> !lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("high read did not unblock");

  property p_wait_to_conv;
    (state == st_wait) && tick && i_ce && o_core_enable |=> s_conv_started;
  endproperty
  a_wait_to_conv: assert property (p_wait_to_conv) else $error("start not on converter tick");

  property p_free_run;
    conv_end && auto_en && (tss == 3'h0) && o_core_enable && !en_wr |=> ##1 s_conv_started;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running stopped");

  property p_cycle_count;
    conv_end |-> (cyc_cnt == (first_pend ? 5'd24 : 5'd12));
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("wrong conversion length");
endmodule : adcc_top
`default_nettype wire

// ==== hw/adcc_trig_edge.sv ====
// Purpose: Rising edge detect on the selected trigger source
// Assumes: Source 0 is the converter's own completion event
// Notes: Every source keeps its own history, so a select change makes no false edge
`timescale 1ns/10ps
`default_nettype none
module adcc_trig_edge #(
  parameter int NSRC = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // Sources
  input wire logic [$clog2(NSRC)-1:0] i_sel,
  input wire logic [NSRC-1:0] i_src,
  input wire logic i_done_pulse,
  // Edge
  output logic o_edge
);
  logic [NSRC-1:0] src_q;
  logic [NSRC-1:0] rise;

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          src_q[g] <= 1'b0;
        end else if (i_ce) begin
          src_q[g] <= i_src[g];
        end
      end
      assign rise[g] = i_src[g] & ~src_q[g];
    end
  endgenerate

  assign o_edge = (i_sel == '0) ? i_done_pulse : rise[i_sel];
endmodule : adcc_trig_edge
`default_nettype wire

// ==== include/adcc_defs.svh ====
// Purpose: Offsets, field positions, reset values and counts of the converter control
// Assumes: APB byte addresses, one aligned word per register
// Notes: Definitions only
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_OFF_CSA 8'h00
`define ADCC_OFF_ISR 8'h04
`define ADCC_OFF_RLO 8'h08
`define ADCC_OFF_RHI 8'h0c
`define ADCC_OFF_SFIO 8'h10
`define ADCC_CSA_EN 7
`define ADCC_CSA_START 6
`define ADCC_CSA_AUTO 5
`define ADCC_CSA_DONE 4
`define ADCC_ISR_REF_HI 7
`define ADCC_ISR_REF_LO 6
`define ADCC_ISR_LADJ 5
`define ADCC_ISR_CH_HI 4
`define ADCC_SFIO_TSS_HI 7
`define ADCC_SFIO_TSS_LO 5
`define ADCC_RST_CH 5'h00
`define ADCC_RST_REF 2'h0
`define ADCC_RST_TSS 3'h0
`define ADCC_CONV_CYC 5'd13
`define ADCC_FIRST_CYC 5'd25
`define ADCC_PRESC_DIV 2
`endif

// ==== include/adcc_pkg.sv ====
// Purpose: Types of the converter control
// Assumes: Nothing
// Notes: Constants live in adcc_defs.svh
package adcc_pkg;
  typedef enum logic [1:0] {st_idle, st_wait, st_conv} adcc_state_t;
endpackage : adcc_pkg

// ==== verif/adcc_core_model.sv ====
// Purpose: Behavioural model of the analog converter core
// Assumes: Result is sampled by the block in the completion cycle
// Notes: Result encodes reference and channel seen at the start pulse
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control from the block
  input wire logic i_enable,
  input wire logic i_start,
  input wire logic [4:0] i_channel,
  input wire logic [1:0] i_ref,
  // Result
  output logic [9:0] o_result
);
  logic [9:0] held;

  // Latch the selection that the conversion really used
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held <= 10'h000;
    end else if (i_start) begin
      held <= {i_ref, i_channel, 3'h5};
    end
  end

  // A switched-off core gives no valid result
  assign o_result = i_enable ? held : ~held;
endmodule : adcc_core_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench of the converter control
// Assumes: PRESC_DIV of 2, core model result {ref, channel, 3'h5}
// Notes: Rows hold a selection and the expected low and high bytes
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, slv;
  logic [7:0] paddr = 8'h00, trig = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cen, cst, done;
  logic [4:0] ch;
  logic [1:0] rf;
  logic [9:0] res;
  int errors = 0, samples_checked = 0, cyc = 0, n_st = 0, t0, s;
  logic [7:0] rows [3][3] = '{'{8'h43, 8'h1d, 8'h01}, '{8'he7, 8'h40, 8'hcf}, '{8'h9f, 8'hfd, 8'h02}};

  adcc_top #(.PRESC_DIV(2), .NSRC(8)) dut (
    .i_clk(clk), .i_arst_n(rst_n), .i_ce(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_trig_src(trig),
    .i_core_result(res), .o_core_enable(cen), .o_core_start(cst), .o_core_channel(ch),
    .o_core_ref(rf), .o_conv_done(done)
  );
  adcc_core_model core (
    .i_clk(clk), .i_arst_n(rst_n), .i_enable(cen), .i_start(cst),
    .i_channel(ch), .i_ref(rf), .o_result(res)
  );

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cst === 1'b1) n_st <= n_st + 1;
  end

  task end_sim;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k >= 20) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task wdone;
    int k;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(posedge clk);
    if (k >= 300) begin
      errors++;
      end_sim();
    end
  endtask : wdone

  task conv(input logic [7:0] sel);
    apb(1'b1, 8'h04, {24'h0, sel});
    apb(1'b1, 8'h00, 32'h90);
    apb(1'b1, 8'h00, 32'hc0);
    t0 = cyc;
  endtask : conv

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b1, 8'h00, 32'h80);
    for (int i = 0; i < 3; i++) begin
      conv(rows[i][0]);
      apb(1'b0, 8'h00, 32'h0);
      chk("busy", {31'h0, rd[6]}, 32'h1);
      wdone();
      if (i == 0) chk("first time", 32'(cyc - t0 >= 49 && cyc - t0 <= 55), 32'h1);
      else chk("conv time", 32'(cyc - t0 >= 25 && cyc - t0 <= 31), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctl done", rd & 32'hf0, 32'h90);
      apb(1'b0, 8'h08, 32'h0);
      chk("low", rd, {24'h0, rows[i][1]});
      apb(1'b0, 8'h0c, 32'h0);
      chk("high", rd, {24'h0, rows[i][2]});
    end
    // Second reset in mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("rst out", {cen, done, rf, ch}, 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctl rst", rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {rd[30:0], slv}, 32'h1);
    apb(1'b1, 8'h04, 32'hc9);
    chk("sel off", {rf, ch}, 32'h0);
    apb(1'b1, 8'h00, 32'h80);
    @(posedge clk);
    chk("sel on", {rf, ch}, 32'h69);
    // Read-order lock
    apb(1'b1, 8'h00, 32'hc0);
    wdone();
    apb(1'b0, 8'h08, 32'h0);
    chk("low a", rd, 32'h4d);
    conv(8'h0a);
    apb(1'b1, 8'h04, 32'h0b);
    chk("chan busy", {27'h0, ch}, 32'h0a);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk("zero start", {31'h0, rd[6]}, 32'h1);
    wdone();
    chk("flag lost", {31'h0, done}, 32'h1);
    repeat (2) @(posedge clk);
    chk("chan after", {27'h0, ch}, 32'h0b);
    apb(1'b0, 8'h0c, 32'h0);
    chk("high a", rd, 32'h03);
    apb(1'b0, 8'h08, 32'h0);
    chk("low kept", rd, 32'h4d);
    apb(1'b0, 8'h0c, 32'h0);
    conv(8'h0b);
    wdone();
    apb(1'b0, 8'h08, 32'h0);
    chk("low c", rd, 32'h5d);
    apb(1'b0, 8'h0c, 32'h0);
    chk("high c", rd, 32'h0);
    // Auto trigger from source 1
    apb(1'b1, 8'h10, 32'h20);
    apb(1'b1, 8'h00, 32'hb0);
    s = n_st;
    trig[1] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("trig start", 32'(n_st), 32'(s + 1));
    apb(1'b0, 8'h00, 32'h0);
    chk("trig busy", {31'h0, rd[6]}, 32'h1);
    trig[1] <= 1'b0;
    @(posedge clk);
    trig[1] <= 1'b1;
    wdone();
    repeat (40) @(posedge clk);
    chk("no restart", 32'(n_st), 32'(s + 1));
    trig[2] <= 1'b1;
    repeat (10) @(posedge clk);
    chk("other src", 32'(n_st), 32'(s + 1));
    apb(1'b1, 8'h00, 32'hb0);
    trig[1] <= 1'b0;
    @(posedge clk);
    trig[1] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("new edge", 32'(n_st), 32'(s + 2));
    wdone();
    // Free running on own completion
    trig <= 8'h00;
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'hb0);
    s = n_st;
    repeat (40) @(posedge clk);
    chk("no self start", 32'(n_st), 32'(s));
    apb(1'b1, 8'h00, 32'hf0);
    repeat (150) @(posedge clk);
    chk("free run", 32'(n_st - s >= 4), 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    repeat (4) @(posedge clk);
    chk("disabled", {31'h0, cen}, 32'h0);
    end_sim();
  end
endmodule : tb
`default_nettype wire
